// ### logic/phy_irq_ctrl_regs.vh
// Register map, field positions, reset values and counts of the PHY regs
`ifndef PHY_IRQ_CTRL_REGS_VH
`define PHY_IRQ_CTRL_REGS_VH

// ****************************************
// Register offsets
// ****************************************
`define OFS_IRQ_STATUS   8'hD4
`define OFS_IRQ_ENABLE   8'hD8
`define OFS_TX_CONTROL   8'hDC

// ****************************************
// Enable / status bit positions
// ****************************************
`define BIT_NEG_DONE     6
`define BIT_REMOTE_FLT   5
`define BIT_LINK_DOWN    4
`define BIT_PARTNER_ACK  3
`define BIT_PAR_DET_FLT  2
`define BIT_PAGE_RX      1
`define BIT_RX_ERR_FULL  0
`define IRQ_EN_MASK      16'h007F

// ****************************************
// Control register fields
// ****************************************
`define BIT_ERR_CNT_OFF  13
`define BIT_NEG_MIRROR   12
`define BIT_REM_LOOP     9
`define BIT_DC_RESTORE   8
`define BIT_LINE_CONV    7
`define BIT_TX_ISOLATE   5
`define BIT_MODE_HI      4
`define BIT_MODE_LO      2
`define BIT_MLT3_BYP     1
`define BIT_SCRAM_BYP    0
`define CTRL_WR_MASK     16'h23A3
`define CTRL_RESET       16'h0180
`define IRQ_EN_RESET     16'h0000

// ****************************************
// Counts
// ****************************************
`define RX_ERR_FULL_CNT  64

`endif

// ### logic/rx_err_counter.v
// Receive error counter that flags when the full count is reached
`timescale 1ns/100ps
`default_nettype none
`include "phy_irq_ctrl_regs.vh"

module rx_err_counter #(
  parameter FULL_CNT = `RX_ERR_FULL_CNT,  // Errors that make it full
  parameter CNT_W    = 7                  // Counter width
) (
  input  wire core_clk_i,  // Core clock
  input  wire rst_n_i,     // Sync reset, active low
  input  wire stop_i,      // Counting halted
  input  wire err_i,       // One erroneous packet
  input  wire clr_i,       // Restart count (flag read)
  output wire full_o       // Count reached full
);

  reg [CNT_W-1:0] cnt_r;    // Error count, saturates
  reg [CNT_W-1:0] cnt_nxt;  // Next count

  localparam [31:0]      FULL_32 = FULL_CNT;              // Full threshold
  localparam [CNT_W-1:0] FULL    = FULL_32[CNT_W-1:0];    // Sized threshold

  // ****************************************
  // Counter next value
  // ****************************************
  always @* begin
    cnt_nxt = cnt_r;
    if (clr_i) begin
      // Read restarts; a coincident error still counts
      cnt_nxt = (err_i && !stop_i) ? {{(CNT_W-1){1'b0}}, 1'b1}
                                   : {CNT_W{1'b0}};
    end else if (err_i && !stop_i && cnt_r != FULL) begin
      cnt_nxt = cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Count register
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cnt_r <= {CNT_W{1'b0}};
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Full only at the threshold, clear below it
  assign full_o = (cnt_nxt == FULL);

endmodule // rx_err_counter

`default_nettype wire

// ### logic/phy_irq_ctrl.v
// Transceiver interrupt enable, status and 100BASE-TX control registers
`timescale 1ns/100ps
`default_nettype none
`include "phy_irq_ctrl_regs.vh"

module phy_irq_ctrl #(
  parameter AW = 8  // Register address width
) (
  input  wire          core_clk_i,            // Core clock 200 MHz
  input  wire          rst_n_i,               // Sync reset, active low
  input  wire [AW-1:0] addr_i,                // Register byte address
  input  wire [15:0]   wdata_i,               // Write data
  input  wire          wr_i,                  // Write strobe
  input  wire          rd_i,                  // Read strobe
  output reg  [15:0]   rdata_o,               // Read data, next cycle
  input  wire          rx_err_i,              // Erroneous packet pulse
  input  wire          neg_done_ev_i,         // Negotiation completed
  input  wire          remote_fault_ev_i,     // Remote fault seen
  input  wire          link_down_ev_i,        // Link failed
  input  wire          partner_ack_ev_i,      // Ack code word received
  input  wire          par_det_fault_ev_i,    // Parallel detect fault
  input  wire          page_rx_ev_i,          // Page received
  input  wire          neg_done_level_i,      // Basic status done bit
  input  wire [2:0]    mode_i,                // Current operating mode
  output wire          phy_irq_o,             // Interrupt request
  output wire          remote_loopback_on_o,  // Remote loopback enable
  output wire          dc_restore_on_o,       // DC restoration enable
  output wire          line_code_convert_on_o,// NRZ/NRZI conversion on
  output wire          transmit_isolate_o,    // Transmit path isolated
  output wire          three_level_bypass_o,  // MLT3 bypassed
  output wire          scrambler_bypass_o     // Scrambler bypassed
);

  // ****************************************
  // Storage
  // ****************************************
  localparam [15:0] EN_RESET = `IRQ_EN_RESET;  // Enable reset word
  reg  [6:0]  irq_en_r;    // Interrupt enables
  reg  [15:0] ctrl_r;      // Writable control bits
  reg  [6:0]  status_r;    // Latched flags
  reg  [6:0]  status_nxt;  // Next flags
  wire [6:0]  events;      // Raw events this cycle
  wire        err_full;    // Counter reached full
  wire        stat_rd;     // Status register read
  wire        ctrl_sel;    // Control register addressed
  wire        en_sel;      // Enable register addressed

  assign stat_rd  = rd_i && (addr_i == `OFS_IRQ_STATUS);
  assign ctrl_sel = (addr_i == `OFS_TX_CONTROL);
  assign en_sel   = (addr_i == `OFS_IRQ_ENABLE);

  // Error counter; restarts when the flag is read out
  rx_err_counter #(
    .FULL_CNT (`RX_ERR_FULL_CNT),
    .CNT_W    (7)
  ) u_err_cnt (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .stop_i     (ctrl_r[`BIT_ERR_CNT_OFF]),
    .err_i      (rx_err_i),
    .clr_i      (stat_rd),
    .full_o     (err_full)
  );

  // Event vector in status bit order
  assign events = {neg_done_ev_i, remote_fault_ev_i, link_down_ev_i,
                   partner_ack_ev_i, par_det_fault_ev_i, page_rx_ev_i,
                   err_full};

  // ****************************************
  // Latched flags, cleared by read
  // ****************************************
  // A new event in the read cycle wins so nothing is lost
  always @* begin
    status_nxt = stat_rd ? 7'h00 : status_r;
    status_nxt = status_nxt | events;
  end

  // Status register
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      status_r <= 7'h00;
    end else begin
      status_r <= status_nxt;
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      irq_en_r <= EN_RESET[6:0];
      ctrl_r   <= `CTRL_RESET;
    end else if (wr_i) begin
      if (en_sel) begin
        irq_en_r <= wdata_i[6:0];
      end
      if (ctrl_sel) begin
        // Read-only and reserved bits never store
        ctrl_r <= wdata_i & `CTRL_WR_MASK;
      end
    end
  end

  // ****************************************
  // Read path, data one cycle after strobe
  // ****************************************
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      case (addr_i)
        `OFS_IRQ_STATUS: rdata_o <= {9'h000, status_r};
        `OFS_IRQ_ENABLE: rdata_o <= {9'h000, irq_en_r};
        `OFS_TX_CONTROL: begin
          rdata_o <= ctrl_r;
          rdata_o[`BIT_NEG_MIRROR] <= neg_done_level_i;
          rdata_o[`BIT_MODE_HI:`BIT_MODE_LO] <= mode_i;
        end
        default:         rdata_o <= 16'h0000;  // Unmapped reads zero
      endcase
    end else begin
      rdata_o <= 16'h0000;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign phy_irq_o              = |(status_r & irq_en_r);
  assign remote_loopback_on_o   = ctrl_r[`BIT_REM_LOOP];
  assign dc_restore_on_o        = ctrl_r[`BIT_DC_RESTORE];
  assign line_code_convert_on_o = ctrl_r[`BIT_LINE_CONV];
  assign transmit_isolate_o     = ctrl_r[`BIT_TX_ISOLATE];
  assign three_level_bypass_o   = ctrl_r[`BIT_MLT3_BYP];
  assign scrambler_bypass_o     = ctrl_r[`BIT_SCRAM_BYP];

endmodule // phy_irq_ctrl

`default_nettype wire

// ### dv/phy_irq_ctrl_props.sv
// Port assertions for the PHY register block
`timescale 1ns/100ps
`default_nettype none
`include "phy_irq_ctrl_regs.vh"
module phy_irq_ctrl_props #(parameter AW = 8) (
  input wire logic core_clk_i, rst_n_i, wr_i, rd_i, rx_err_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [15:0] wdata_i, rdata_o,
  input wire logic neg_done_ev_i, remote_fault_ev_i, link_down_ev_i,
  input wire logic partner_ack_ev_i, par_det_fault_ev_i, page_rx_ev_i,
  input wire logic neg_done_level_i, phy_irq_o, remote_loopback_on_o,
  input wire logic dc_restore_on_o, line_code_convert_on_o,
  input wire logic transmit_isolate_o, three_level_bypass_o,
  input wire logic scrambler_bypass_o,
  input wire logic [2:0] mode_i
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Any event that could re-latch a flag in the read cycle
  wire ev = rx_err_i | neg_done_ev_i | remote_fault_ev_i |
            link_down_ev_i | partner_ack_ev_i | par_det_fault_ev_i |
            page_rx_ev_i;
  wire cw = wr_i && addr_i == `OFS_TX_CONTROL;
  AST_LOOP: assert property (
    cw |=> remote_loopback_on_o == $past(wdata_i[9]))
    else $error("loopback bit wrong");
  AST_DCR_CONV: assert property (
    cw |=> {dc_restore_on_o, line_code_convert_on_o} == $past(wdata_i[8:7]))
    else $error("restore or convert bit wrong");
  AST_BYPASS: assert property (
    cw |=> {transmit_isolate_o, three_level_bypass_o, scrambler_bypass_o}
      == {$past(wdata_i[5]), $past(wdata_i[1:0])})
    else $error("isolate or bypass bit wrong");
  AST_MIRROR: assert property (
    rd_i && addr_i == `OFS_TX_CONTROL |=> rdata_o[12] == $past(neg_done_level_i))
    else $error("negotiation mirror wrong");
  AST_MODE: assert property (
    rd_i && addr_i == `OFS_TX_CONTROL |=> rdata_o[4:2] == $past(mode_i))
    else $error("mode report wrong");
  AST_MASK: assert property (
    wr_i && addr_i == `OFS_IRQ_ENABLE && wdata_i[6:0] == 7'h00 |=> !phy_irq_o)
    else $error("request with all enables off");
  AST_CLR: assert property (
    rd_i && addr_i == `OFS_IRQ_STATUS && !ev |=> !phy_irq_o)
    else $error("request after status read");
  AST_IDLE: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("read data outside read slot");
endmodule // phy_irq_ctrl_props
bind phy_irq_ctrl phy_irq_ctrl_props #(.AW(AW)) props_i (.core_clk_i,
  .rst_n_i, .wr_i, .rd_i, .rx_err_i, .addr_i, .wdata_i, .rdata_o,
  .neg_done_ev_i, .remote_fault_ev_i, .link_down_ev_i, .partner_ack_ev_i,
  .par_det_fault_ev_i, .page_rx_ev_i, .neg_done_level_i, .phy_irq_o,
  .remote_loopback_on_o, .dc_restore_on_o, .line_code_convert_on_o,
  .transmit_isolate_o, .three_level_bypass_o, .scrambler_bypass_o, .mode_i);
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the PHY register block
`timescale 1ns/100ps
`default_nettype none
`include "phy_irq_ctrl_regs.vh"
module testbench;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, err = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wd = 16'h0000;
  logic [5:0] ev = 6'h00; // Event pulses, status bits 6..1
  logic ndl = 1'b0;
  logic [2:0] mode = 3'h0;
  wire [15:0] rdo;
  wire irq, lb, dcr, cnv, iso, mlt, scr;
  int error_cnt = 0, total_checks = 0;
  always #2.5 clk = ~clk;
  phy_irq_ctrl phy_irq_ctrl_i (.core_clk_i(clk), .rst_n_i(rst_n),
    .addr_i(addr), .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdo),
    .rx_err_i(err), .neg_done_ev_i(ev[5]), .remote_fault_ev_i(ev[4]),
    .link_down_ev_i(ev[3]), .partner_ack_ev_i(ev[2]),
    .par_det_fault_ev_i(ev[1]), .page_rx_ev_i(ev[0]),
    .neg_done_level_i(ndl), .mode_i(mode), .phy_irq_o(irq),
    .remote_loopback_on_o(lb), .dc_restore_on_o(dcr),
    .line_code_convert_on_o(cnv), .transmit_isolate_o(iso),
    .three_level_bypass_o(mlt), .scrambler_bypass_o(scr));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) begin wr <= 1'b1; addr <= a; wd <= d; end
    @(posedge clk) wr <= 1'b0;
    #1;
  endtask
  // Data checked in the single cycle it stands
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk) begin rd <= 1'b1; addr <= a; end
    @(posedge clk) rd <= 1'b0;
    #1 chk(rdo, e);
  endtask
  task automatic pulse(input logic [5:0] e, input logic x, input int n);
    repeat (n) begin
      @(posedge clk) begin ev <= e; err <= x; end
      @(posedge clk) begin ev <= 6'h00; err <= 1'b0; end
    end
    #1;
  endtask
  task automatic t_reset;
    #1 chk({lb, dcr, cnv, iso, mlt, scr, irq}, 16'h0030);
    rd_reg(`OFS_TX_CONTROL, 16'h0180);
    rd_reg(`OFS_IRQ_ENABLE, 16'h0000);
    rd_reg(8'h40, 16'h0000);
  endtask
  task automatic t_ctrl;
    @(posedge clk) ndl <= 1'b1;
    wr_reg(`OFS_TX_CONTROL, 16'hFFFF);
    chk({lb, dcr, cnv, iso, mlt, scr}, 16'h003F);
    for (int m = 0; m < 8; m++) begin
      @(posedge clk) mode <= m[2:0];
      rd_reg(`OFS_TX_CONTROL, 16'h33A3 | {m[2:0], 2'b00});
    end
    wr_reg(`OFS_TX_CONTROL, 16'h0000);
    chk({lb, dcr, cnv, iso, mlt, scr}, 16'h0000);
    wr_reg(`OFS_TX_CONTROL, 16'h0180);
  endtask
  // Each of the six pulse sources alone, first with only its own enable off
  task automatic t_irq;
    for (int i = 0; i < 6; i++) begin
      wr_reg(`OFS_IRQ_ENABLE, 16'h007F ^ (16'h0002 << i));
      pulse(6'h01 << i, 1'b0, 1);
      chk(irq, 16'h0000);
      wr_reg(`OFS_IRQ_ENABLE, 16'h0002 << i);
      chk(irq, 16'h0001);
      rd_reg(`OFS_IRQ_STATUS, 16'h0002 << i);
      chk(irq, 16'h0000);
    end
    wr_reg(`OFS_IRQ_ENABLE, 16'h0000);
  endtask
  task automatic t_err;
    wr_reg(`OFS_IRQ_ENABLE, 16'h0001);
    pulse(6'h00, 1'b1, 63);
    chk(irq, 16'h0000);
    pulse(6'h00, 1'b1, 1);
    chk(irq, 16'h0001);
    rd_reg(`OFS_IRQ_STATUS, 16'h0001);
    wr_reg(`OFS_TX_CONTROL, 16'h2180);
    pulse(6'h00, 1'b1, 64);
    chk(irq, 16'h0000);
    wr_reg(`OFS_TX_CONTROL, 16'h0180);
    pulse(6'h00, 1'b1, 64);
    chk(irq, 16'h0001);
    wr_reg(`OFS_IRQ_ENABLE, 16'h007E);
    chk(irq, 16'h0000);
    rd_reg(`OFS_IRQ_STATUS, 16'h0001);
    rd_reg(`OFS_IRQ_STATUS, 16'h0000);
  endtask
  // Reset again mid-run, after control and enables were changed
  task automatic t_mid_reset;
    wr_reg(`OFS_TX_CONTROL, 16'h23A3);
    @(posedge clk) begin rst_n <= 1'b0; ndl <= 1'b0; mode <= 3'h0; end
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    rd_reg(`OFS_IRQ_STATUS, 16'h0000);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_ctrl;
    t_irq;
    t_err;
    t_mid_reset;
    wrap_up;
  end
  // Whole run is under a thousand cycles
  initial begin
    #20000;
    error_cnt++;
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
